// [tb/lin_bus_model.sv]
// Behavioural LIN bus: one pulled-up wire shared with a remote node.
// Assumes the device drive output is a level in the core clock domain.
`timescale 1ns/1ps
module lin_bus_model (
   input  wire logic drive_dominant_i,
   input  wire logic remote_dominant_i,
   output logic      bus_level_o
);
   // The pull-up holds the line recessive unless any node pulls it low.
   assign bus_level_o = !(drive_dominant_i || remote_dominant_i);
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the LIN SBC mode and pin control.
// Assumes three core clocks from a pin change to a registered output.
`timescale 1ns/1ps
module tb_top;
   import lin_sbc_pkg::*;
   localparam int unsigned DOM = 50;
   logic core_clk_i = 0, resetn_i = 0, en_i = 0, txd_i = 1, lin_bus_i;
   logic local_wake_input_i = 1, ignition_wake_input_i = 0;
   logic high_side_control_i = 0, high_side_fault_i = 0;
   logic low_side1_control_i = 0, low_side2_control_i = 0;
   logic low_side1_fault_i = 0, low_side2_fault_i = 0;
   logic vs_undervoltage_i = 0, lin_wake_i = 0, watchdog_trigger_n_i = 1;
   logic watchdog_mode_i = 0, watchdog_reset_i = 0, remote_dom = 0;
   logic lin_drive_dominant_o, rxd_o, txd_o, txd_oe_o, wake_mirror_output_o;
   logic high_side_output_o, low_side1_output_o, low_side2_output_o;
   logic regulator_on_o, watchdog_enable_o, watchdog_trigger_o;
   logic limp_home_out_o;
   mode_type mode_o;
   int n_fail = 0, check_count = 0, trig_seen = 0, i, exp_trig;
   integer seed = 32'h89fc02a1, r;

   always #12.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) if (watchdog_trigger_o === 1'b1) trig_seen++;

   lin_sbc_ctrl #(.DOM_CYC(DOM)) dut (.core_clk_i, .resetn_i, .en_i, .txd_i,
      .lin_bus_i, .local_wake_input_i, .ignition_wake_input_i,
      .high_side_control_i, .high_side_fault_i, .low_side1_control_i,
      .low_side2_control_i, .low_side1_fault_i, .low_side2_fault_i,
      .vs_undervoltage_i, .lin_wake_i, .watchdog_trigger_n_i,
      .watchdog_mode_i, .watchdog_reset_i, .lin_drive_dominant_o, .rxd_o,
      .txd_o, .txd_oe_o, .wake_mirror_output_o, .high_side_output_o,
      .low_side1_output_o, .low_side2_output_o, .regulator_on_o,
      .watchdog_enable_o, .watchdog_trigger_o, .limp_home_out_o, .mode_o);
   lin_bus_model bus (.drive_dominant_i(lin_drive_dominant_o),
      .remote_dominant_i(remote_dom), .bus_level_o(lin_bus_i));

   task automatic print_verdict();
      if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic ck(input logic [1:0] s, input logic [1:0] e);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t: saw %b expected %b", $time, s, e);
      end
   endtask
   // Waits end on a rising edge so stimulus lands there.
   task automatic w(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // Settles just after an edge so registered outputs are read safely.
   task automatic s(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic fs(input logic t, input logic x);
      ck(mode_o, MODE_FAILSAFE);
      ck(txd_oe_o, 1);
      ck(txd_o, t);
      ck(rxd_o, x);
   endtask
   task automatic trig(input int n);
      w(1); watchdog_trigger_n_i <= 0;
      w(n); watchdog_trigger_n_i <= 1;
      s(50);
   endtask
   task automatic pulse_wdr();
      w(1); watchdog_reset_i <= 1;
      w(1); watchdog_reset_i <= 0;
      s(6);
   endtask

   initial begin
      #1000000;
      n_fail++;
      print_verdict();
   end

   initial begin
      w(4); resetn_i <= 1; s(2);
      fs(0, 0);
      ck(regulator_on_o, 1); ck(limp_home_out_o, 0);
      w(1); en_i <= 1; s(6);
      ck(mode_o, MODE_NORMAL); ck(txd_oe_o, 0);
      ck(regulator_on_o, 1);
      for (i = 0; i < 8; i++) begin
         r = $random(seed); w(1); remote_dom <= r[0]; s(6);
         ck(rxd_o, !r[0]);
      end
      w(1); remote_dom <= 0; txd_i <= 0; s(6);
      ck(lin_drive_dominant_o, 1); ck(rxd_o, 0);
      s(DOM); ck(lin_drive_dominant_o, 0);
      w(1); txd_i <= 1; w(100); txd_i <= 0; s(6);
      ck(lin_drive_dominant_o, 0);
      w(1); txd_i <= 1; w(420); txd_i <= 0; s(6);
      ck(lin_drive_dominant_o, 1);
      w(1); txd_i <= 1; watchdog_mode_i <= 1; s(6);
      ck(watchdog_enable_o, 0);
      w(1); watchdog_mode_i <= 0; s(6);
      ck(watchdog_enable_o, 1);
      pulse_wdr(); ck(limp_home_out_o, 1);
      exp_trig = trig_seen; trig(10);
      ck(trig_seen == exp_trig, 1);
      for (i = 0; i < 3; i++) begin
         ck(limp_home_out_o, 1);
         trig(45);
      end
      ck(limp_home_out_o, 0); ck(trig_seen == exp_trig + 3, 1);
      pulse_wdr();
      w(1); local_wake_input_i <= 0; high_side_control_i <= 1; s(6);
      ck(wake_mirror_output_o, 1); ck(high_side_output_o, 1);
      ck(mode_o, MODE_NORMAL);
      w(1); local_wake_input_i <= 1; high_side_fault_i <= 1;
      w(1); high_side_fault_i <= 0; s(6);
      ck(wake_mirror_output_o, 0); ck(high_side_output_o, 0);
      w(1); high_side_control_i <= 0; w(6); high_side_control_i <= 1; s(6);
      ck(high_side_output_o, 1);
      w(1); low_side1_control_i <= 1; low_side2_control_i <= 1; s(100);
      ck(low_side1_output_o, 0);
      s(330); ck(low_side1_output_o, 1); ck(low_side2_output_o, 1);
      w(1); low_side2_fault_i <= 1; w(1); low_side2_fault_i <= 0; s(6);
      ck(low_side2_output_o, 0); ck(low_side1_output_o, 1);
      w(1); vs_undervoltage_i <= 1; s(6);
      ck(low_side1_output_o, 0);
      fs(1, 0);
      w(1); vs_undervoltage_i <= 0; en_i <= 0; s(6);
      ck(mode_o, MODE_SILENT); ck(regulator_on_o, 1);
      ck(rxd_o, 1); ck(limp_home_out_o, 1);
      ck(high_side_output_o, 1);
      w(1); local_wake_input_i <= 0; s(6);
      fs(0, 1); ck(wake_mirror_output_o, 1);
      w(1); local_wake_input_i <= 1; txd_i <= 0; en_i <= 1; s(6);
      ck(mode_o, MODE_NORMAL); ck(lin_drive_dominant_o, 0);
      w(1); txd_i <= 1; ignition_wake_input_i <= 1; w(420); txd_i <= 0; s(6);
      ck(lin_drive_dominant_o, 1);
      s(4100); w(1); en_i <= 0; s(6);
      ck(mode_o, MODE_SLEEP); ck(regulator_on_o, 0);
      ck(high_side_output_o, 0);
      s(200); ck(mode_o, MODE_SLEEP);
      w(1); ignition_wake_input_i <= 0; s(4100);
      w(1); ignition_wake_input_i <= 1; s(3000);
      ck(mode_o, MODE_SLEEP);
      s(1200); fs(0, 1); ck(limp_home_out_o, 0);
      w(1); en_i <= 1; s(6);
      w(1); en_i <= 0; s(6);
      ck(mode_o, MODE_SLEEP);
      w(1); lin_wake_i <= 1; w(1); lin_wake_i <= 0; s(6);
      fs(0, 0);
      print_verdict();
   end
endmodule

// [verilog/lin_sbc_ctrl.sv]
// Mode and pin control of a LIN system basis chip.
// Assumes analog blocks report bus level, faults and wake events as pins.
`timescale 1ns/1ps
module lin_sbc_ctrl #(
   parameter int unsigned DOM_CYC = lin_sbc_pkg::DOM_TIMEOUT_CYC
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 resetn_i,
   input  wire logic                 en_i,
   input  wire logic                 txd_i,
   input  wire logic                 lin_bus_i,
   input  wire logic                 local_wake_input_i,
   input  wire logic                 ignition_wake_input_i,
   input  wire logic                 high_side_control_i,
   input  wire logic                 high_side_fault_i,
   input  wire logic                 low_side1_control_i,
   input  wire logic                 low_side2_control_i,
   input  wire logic                 low_side1_fault_i,
   input  wire logic                 low_side2_fault_i,
   input  wire logic                 vs_undervoltage_i,
   input  wire logic                 lin_wake_i,
   input  wire logic                 watchdog_trigger_n_i,
   input  wire logic                 watchdog_mode_i,
   input  wire logic                 watchdog_reset_i,
   output logic                      lin_drive_dominant_o,
   output logic                      rxd_o,
   output logic                      txd_o,
   output logic                      txd_oe_o,
   output logic                      wake_mirror_output_o,
   output logic                      high_side_output_o,
   output logic                      low_side1_output_o,
   output logic                      low_side2_output_o,
   output logic                      regulator_on_o,
   output logic                      watchdog_enable_o,
   output logic                      watchdog_trigger_o,
   output logic                      limp_home_out_o,
   output lin_sbc_pkg::mode_type     mode_o
);
   import lin_sbc_pkg::*;

   function automatic logic [8:0] sat_inc9(input logic [8:0] v,
                                           input logic [8:0] lim);
      sat_inc9 = (v >= lim) ? lim : 9'(v + 9'h001);
   endfunction

   pin_sync_if pins ();

   assign pins.raw = {watchdog_reset_i, watchdog_mode_i,
                      watchdog_trigger_n_i, lin_wake_i, vs_undervoltage_i,
                      low_side2_fault_i, low_side1_fault_i,
                      low_side2_control_i, low_side1_control_i,
                      high_side_fault_i, high_side_control_i,
                      ignition_wake_input_i, local_wake_input_i,
                      lin_bus_i, txd_i, en_i};

   pin_sync u_sync (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .pins       (pins.sync_side)
   );

   logic en_s;
   logic txd_s;
   logic bus_s;
   logic lwake_s;
   logic ign_s;
   logic uv_s;
   logic trig_n_s;
   logic [2:0] ctl_s;
   logic [2:0] fault_s;

   assign en_s     = pins.synced[S_EN];
   assign txd_s    = pins.synced[S_TXD];
   assign bus_s    = pins.synced[S_BUS];
   assign lwake_s  = pins.synced[S_LWAKE];
   assign ign_s    = pins.synced[S_IGN];
   assign uv_s     = pins.synced[S_UV];
   assign trig_n_s = pins.synced[S_TRIGN];
   assign ctl_s    = {pins.synced[S_LS2], pins.synced[S_LS1],
                      pins.synced[S_HS]};
   assign fault_s  = {pins.synced[S_LS2F], pins.synced[S_LS1F],
                      pins.synced[S_HSF]};

   // Edge detection on synced levels; ignition on its debounced level.
   logic en_d_reg;
   logic lwake_d_reg;
   logic ign_db_reg;
   logic ign_db_d_reg;
   logic trig_n_d_reg;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         en_d_reg     <= 1'b0;
         lwake_d_reg  <= 1'b1;
         ign_db_d_reg <= 1'b0;
         trig_n_d_reg <= 1'b1;
      end else begin
         en_d_reg     <= en_s;
         lwake_d_reg  <= lwake_s;
         ign_db_d_reg <= ign_db_reg;
         trig_n_d_reg <= trig_n_s;
      end
   end

   logic en_fall;
   logic lwake_fall;
   logic ign_rise;
   assign en_fall    = en_d_reg & ~en_s;
   assign lwake_fall = lwake_d_reg & ~lwake_s;
   assign ign_rise   = ign_db_reg & ~ign_db_d_reg;

   // Ignition debounce: a new level must stand for the full time.
   logic [11:0] ign_cnt_reg;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ign_cnt_reg <= 12'h000;
         ign_db_reg  <= 1'b0;
      end else if (ign_s == ign_db_reg) begin
         ign_cnt_reg <= 12'h000;
      end else if (ign_cnt_reg >= IGN_DEBOUNCE_CYC - 12'h001) begin
         ign_cnt_reg <= 12'h000;
         ign_db_reg  <= ign_s;
      end else begin
         ign_cnt_reg <= ign_cnt_reg + 12'h001;
      end
   end

   // Operating mode.
   mode_type  mode_reg;
   mode_type  mode_next;
   cause_type cause_reg;
   cause_type cause_next;
   logic      uv_entry_reg;

   always_comb begin
      mode_next  = mode_reg;
      cause_next = cause_reg;
      case (mode_reg)
         MODE_FAILSAFE: begin
            // An undervoltage entry keeps enable high, so hold until it ends.
            if (en_s && !uv_s) begin
               mode_next = MODE_NORMAL;
            end else if (uv_entry_reg && en_fall) begin
               mode_next = txd_s ? MODE_SILENT : MODE_SLEEP;
            end
         end
         MODE_NORMAL: begin
            if (en_fall) begin
               // Raw level decides, not the gated driver.
               mode_next = txd_s ? MODE_SILENT : MODE_SLEEP;
            end else if (uv_s) begin
               mode_next  = MODE_FAILSAFE;
               cause_next = CAUSE_UV;
            end
         end
         MODE_SILENT, MODE_SLEEP: begin
            if (lwake_fall || ign_rise) begin
               mode_next  = MODE_FAILSAFE;
               cause_next = CAUSE_LOCAL;
            end else if (lin_wake_i) begin
               mode_next  = MODE_FAILSAFE;
               cause_next = CAUSE_BUS;
            end
         end
         default: begin
            mode_next = MODE_FAILSAFE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_reg     <= MODE_FAILSAFE;
         cause_reg    <= CAUSE_POWER;
         uv_entry_reg <= 1'b0;
      end else begin
         mode_reg  <= mode_next;
         cause_reg <= cause_next;
         if (mode_reg == MODE_NORMAL && mode_next == MODE_FAILSAFE) begin
            uv_entry_reg <= 1'b1;
         end else if (mode_next != MODE_FAILSAFE) begin
            uv_entry_reg <= 1'b0;
         end
      end
   end

   logic enter_normal;
   assign enter_normal = (mode_next == MODE_NORMAL) &&
                         (mode_reg != MODE_NORMAL);

   // High-time qualifiers: index 0 transmit, 1 and 2 the low-side inputs.
   logic [2:0] qual_in;
   logic [2:0] hi_ok;
   logic [8:0] hi_cnt_reg [3];
   logic [2:0] block_reg;
   logic [2:0] latch_reg;
   logic [19:0] dom_cnt_reg;
   logic        dom_hit;

   assign qual_in = {ctl_s[2], ctl_s[1], txd_s};
   assign dom_hit = dom_cnt_reg >= 20'(DOM_CYC);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < 3; i++) begin
            hi_cnt_reg[i] <= 9'h000;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            hi_cnt_reg[i] <= qual_in[i] ?
               sat_inc9(hi_cnt_reg[i], HIGH_QUAL_CYC) : 9'h000;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         hi_ok[i] = hi_cnt_reg[i] >= HIGH_QUAL_CYC;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dom_cnt_reg <= 20'h00000;
      end else if (mode_reg == MODE_NORMAL && !txd_s) begin
         if (!dom_hit) begin
            dom_cnt_reg <= dom_cnt_reg + 20'h00001;
         end
      end else begin
         dom_cnt_reg <= 20'h00000;
      end
   end

   // Driver blocks: set at entry with input low or, for transmit only, on dominant timeout.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         block_reg <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (enter_normal && !qual_in[i]) begin
               block_reg[i] <= 1'b1;
            end else if (i == 0 && dom_hit) begin
               block_reg[i] <= 1'b1;
            end else if (hi_ok[i]) begin
               block_reg[i] <= 1'b0;
            end
         end
      end
   end

   // Overload latches; index 0 high-side, 1 and 2 low-side. Set wins.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         latch_reg <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (fault_s[i]) begin
               latch_reg[i] <= 1'b1;
            end else if (!ctl_s[i]) begin
               latch_reg[i] <= 1'b0;
            end
         end
      end
   end

   // Watchdog trigger qualification and limp-home.
   logic [5:0] trig_cnt_reg;
   logic [1:0] good_cnt_reg;
   logic       lh_reg;
   logic       trig_ok;
   logic       wd_reset_ev;
   logic       wd_active;

   assign wd_active   = ~pins.synced[S_WDMODE] &&
                        (mode_reg == MODE_NORMAL ||
                         mode_reg == MODE_FAILSAFE);
   assign trig_ok     = !trig_n_s && trig_cnt_reg == TRIG_MIN_CYC - 6'h01;
   assign wd_reset_ev = wd_active && pins.synced[S_WDRST];

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trig_cnt_reg <= 6'h00;
      end else if (trig_n_s || trig_n_d_reg && !trig_n_s) begin
         trig_cnt_reg <= 6'h00;
      end else if (trig_cnt_reg < TRIG_MIN_CYC) begin
         trig_cnt_reg <= trig_cnt_reg + 6'h01;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lh_reg       <= 1'b0;
         good_cnt_reg <= 2'h0;
      end else if (mode_reg == MODE_SLEEP && mode_next != MODE_SLEEP) begin
         lh_reg       <= 1'b0;
         good_cnt_reg <= 2'h0;
      end else if (wd_reset_ev) begin
         lh_reg       <= 1'b1;
         good_cnt_reg <= 2'h0;
      end else if (wd_active && trig_ok && lh_reg) begin
         if (good_cnt_reg == LH_CLEAR_TRIGGERS - 2'h1) begin
            lh_reg       <= 1'b0;
            good_cnt_reg <= 2'h0;
         end else begin
            good_cnt_reg <= good_cnt_reg + 2'h1;
         end
      end
   end

   // Registered pin outputs.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lin_drive_dominant_o <= 1'b0;
         rxd_o                <= 1'b0;
         txd_o                <= 1'b0;
         txd_oe_o             <= 1'b0;
         wake_mirror_output_o <= 1'b0;
         high_side_output_o   <= 1'b0;
         low_side1_output_o   <= 1'b0;
         low_side2_output_o   <= 1'b0;
         regulator_on_o       <= 1'b1;
         watchdog_enable_o    <= 1'b0;
         watchdog_trigger_o   <= 1'b0;
      end else begin
         lin_drive_dominant_o <= mode_reg == MODE_NORMAL && !txd_s &&
                                 !block_reg[0] && !dom_hit;
         case (mode_reg)
            MODE_NORMAL:   rxd_o <= bus_s;
            MODE_SILENT:   rxd_o <= 1'b1;
            MODE_FAILSAFE: rxd_o <= cause_reg == CAUSE_LOCAL;
            default:       rxd_o <= 1'b0;
         endcase
         txd_o    <= cause_reg == CAUSE_UV;
         txd_oe_o <= mode_reg == MODE_FAILSAFE;
         wake_mirror_output_o <= mode_reg != MODE_SLEEP && !lwake_s;
         high_side_output_o <= ctl_s[0] && !latch_reg[0] &&
                               mode_reg != MODE_SLEEP;
         low_side1_output_o <= ctl_s[1] && !latch_reg[1] && !block_reg[1] &&
                               mode_reg == MODE_NORMAL && !uv_s;
         low_side2_output_o <= ctl_s[2] && !latch_reg[2] && !block_reg[2] &&
                               mode_reg == MODE_NORMAL && !uv_s;
         regulator_on_o     <= mode_reg != MODE_SLEEP;
         watchdog_enable_o  <= ~pins.synced[S_WDMODE];
         watchdog_trigger_o <= wd_active && trig_ok;
      end
   end

   assign limp_home_out_o = lh_reg;
   assign mode_o          = mode_reg;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   a_rx_silent_high: assert property (
      mode_reg == MODE_SILENT |=> rxd_o)
      else $error("receive output not high in silent mode");
   a_rx_follows_bus: assert property (
      mode_reg == MODE_NORMAL |=> rxd_o == $past(bus_s))
      else $error("receive output does not follow bus");
   a_tx_high_recessive: assert property (
      txd_s |=> !lin_drive_dominant_o)
      else $error("bus driven while transmit high");
   a_dom_timeout_off: assert property (
      dom_hit |=> !lin_drive_dominant_o ##1 !lin_drive_dominant_o)
      else $error("driver active after dominant timeout");
   a_sleep_select: assert property (
      mode_reg == MODE_NORMAL && en_fall && !txd_s
      |=> mode_reg == MODE_SLEEP ##1 !regulator_on_o)
      else $error("sleep mode not entered");
   a_silent_select: assert property (
      mode_reg == MODE_NORMAL && en_fall && txd_s
      |=> mode_reg == MODE_SILENT ##1 regulator_on_o)
      else $error("silent mode not entered");
   a_wake_mirror_inv: assert property (
      mode_reg != MODE_SLEEP
      |=> wake_mirror_output_o == !$past(lwake_s))
      else $error("wake output not inverse of local wake");
   a_local_wake_fs: assert property (
      mode_reg == MODE_SILENT && lwake_fall
      |=> mode_reg == MODE_FAILSAFE ##1 wake_mirror_output_o)
      else $error("local wake did not enter fail-safe");
   a_hs_off_sleep: assert property (
      mode_reg == MODE_SLEEP |=> !high_side_output_o)
      else $error("high-side on in sleep mode");
   a_ls_normal_only: assert property (
      mode_reg != MODE_NORMAL
      |=> !low_side1_output_o && !low_side2_output_o)
      else $error("low-side on outside normal mode");
   a_lh_on_reset: assert property (
      wd_reset_ev |=> limp_home_out_o)
      else $error("limp-home not set on watchdog reset");
   a_fs_bus_code: assert property (
      mode_reg == MODE_FAILSAFE && cause_reg == CAUSE_BUS
      |=> txd_oe_o && !txd_o && !rxd_o)
      else $error("wrong fail-safe code for bus wake");

   c_normal_to_silent: cover property (
      mode_reg == MODE_NORMAL ##1 mode_reg == MODE_SILENT);
   c_sleep_wake: cover property (
      mode_reg == MODE_SLEEP ##1 mode_reg == MODE_FAILSAFE);
   c_lh_cleared: cover property (limp_home_out_o ##1 !limp_home_out_o);
   c_dom_timeout: cover property (mode_reg == MODE_NORMAL && dom_hit);
endmodule

// [verilog/lin_sbc_pkg.sv]
// Constants, types and pin indices for the LIN SBC mode and pin control.
// Assumes one 40 MHz core clock; all time figures derive from its period.
package lin_sbc_pkg;

   localparam int CLK_PERIOD_NS = 25;

   // Qualification high time for the transmit and low-side inputs.
   localparam int HIGH_QUAL_NS = 10000;
   localparam logic [8:0] HIGH_QUAL_CYC =
      9'(HIGH_QUAL_NS / CLK_PERIOD_NS + 1);

   // Dominant timeout on the transmit input.
   localparam int DOM_TIMEOUT_US = 20000;
   localparam int DOM_TIMEOUT_CYC =
      DOM_TIMEOUT_US * 1000 / CLK_PERIOD_NS + 1;

   // Ignition wake debounce time.
   localparam int IGN_DEBOUNCE_NS = 100000;
   localparam logic [11:0] IGN_DEBOUNCE_CYC =
      12'(IGN_DEBOUNCE_NS / CLK_PERIOD_NS);

   // Minimum low width of a watchdog trigger pulse.
   localparam int TRIG_MIN_NS = 1000;
   localparam logic [5:0] TRIG_MIN_CYC =
      6'((TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam logic [1:0] LH_CLEAR_TRIGGERS = 2'h3;

   // Synchronised pin vector layout.
   localparam int SYNC_W   = 16;
   localparam int S_EN     = 0;
   localparam int S_TXD    = 1;
   localparam int S_BUS    = 2;
   localparam int S_LWAKE  = 3;
   localparam int S_IGN    = 4;
   localparam int S_HS     = 5;
   localparam int S_HSF    = 6;
   localparam int S_LS1    = 7;
   localparam int S_LS2    = 8;
   localparam int S_LS1F   = 9;
   localparam int S_LS2F   = 10;
   localparam int S_UV     = 11;
   localparam int S_LINWK  = 12;
   localparam int S_TRIGN  = 13;
   localparam int S_WDMODE = 14;
   localparam int S_WDRST  = 15;
   // Pulled-up pins idle high: transmit, bus, local wake, trigger.
   localparam logic [15:0] SYNC_RST = 16'h200e;

   typedef enum logic [1:0] {
      MODE_FAILSAFE = 2'b00,
      MODE_NORMAL   = 2'b01,
      MODE_SILENT   = 2'b10,
      MODE_SLEEP    = 2'b11
   } mode_type;

   typedef enum logic [1:0] {
      CAUSE_POWER = 2'b00,
      CAUSE_BUS   = 2'b01,
      CAUSE_LOCAL = 2'b10,
      CAUSE_UV    = 2'b11
   } cause_type;

endpackage

// [verilog/pin_sync.sv]
// Two-stage synchroniser bank for every asynchronous pin input.
// Assumes the reset values match the idle level of each pin.
`timescale 1ns/1ps
module pin_sync
   import lin_sbc_pkg::*;
(
   input  wire logic   core_clk_i,
   input  wire logic   resetn_i,
   pin_sync_if.sync_side pins
);
   logic [15:0] stage1_reg;
   logic [15:0] stage2_reg;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage1_reg <= SYNC_RST;
         stage2_reg <= SYNC_RST;
      end else begin
         stage1_reg <= pins.raw;
         stage2_reg <= stage1_reg;
      end
   end

   assign pins.synced = stage2_reg;
endmodule

// [verilog/pin_sync_if.sv]
// Carries raw pin levels into the synchroniser and synced levels back.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface pin_sync_if;
   logic [15:0] raw;
   logic [15:0] synced;
   modport sync_side (input raw, output synced);
   modport user_side (output raw, input synced);
endinterface
